// [dlicr_config_regs.sv]
/*
 * Link configuration registers at 0x3, 0x4 and 0x5 with the logic they steer:
 * back-channel control, sync and serial-bus glitch filters, SDA hold,
 * transaction forwarding, write acknowledge, pixel gating, channel watchdog.
 * Assumes the serial-bus target engine presents register accesses on the
 * reg* port, one cycle per access, and all inputs are synchronous to mclk.
 */
// Operation
// - Link config bit 6 set enables back-channel CRC generation; clear omits it.
// - Bit 5 set pulls undriven inputs down, clear pulls up; resets to one.
// - Sync filter bit 4 rejects pulses under two clocks on DE, HS, VS.
// - In dual-lane mode the HS filter needs four clocks instead of two.
// - Bit 3 forwards local transactions whose address matches a remote target.
// - Bit 2 acknowledges writes automatically regardless of forward lock.
// - Protected-capable partner: pixel data always gated by DE, bit 1 ignored.
// - Other partner: pixel data passes ungated unless bit 1 is set.
// - Watchdog timeout is field bits 7..1 in 2 ms steps, resets all ones.
// - An unfinished channel transaction is terminated when the timeout expires.
// - Watchdog bit 0 set disables the timer; zero (reset) runs it.
// - Forward-all bit 7 sends every transaction across, ignoring address match.
// - SDA hold time relative to SCL is bits 6..4 times 50 ns.
// - SCL and SDA glitches up to bits 3..0 times 5 ns are rejected.
// - Back channel turns off only when enable and both forward bits are clear.
`timescale 1ns/1ps
`include "dlicr_consts.svh"
module dlicr_config_regs
    import dlicr_pkg::*;
#(
    parameter int TO_STEP_CYCLES = `DLICR_TO_STEP_MS * 1000000 / `DLICR_CLK_PERIOD_NS
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire dlicr_byte_t regAddr,
    input wire dlicr_byte_t regWrData,
    output dlicr_byte_t regRdData,
    input wire logic backChanOn,
    input wire logic dualLane,
    input wire logic partnerProtected,
    input wire logic deIn,
    input wire logic hsIn,
    input wire logic vsIn,
    input wire dlicr_pixel_t pixIn,
    output logic deOut,
    output logic hsOut,
    output logic vsOut,
    output dlicr_pixel_t pixOut,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclClean,
    output logic sdaHeld,
    input wire logic txnStart,
    input wire logic addrMatch,
    output logic fwdToRemote,
    input wire logic wrAddressed,
    input wire logic fwdLocked,
    output logic wrAck,
    input wire logic ccBusy,
    output logic ccAbort,
    output logic backChanActive,
    output logic backChanCrcGenEn,
    output logic undrivenInputPullSel
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    dlicr_byte_t linkMisc_ff;
    dlicr_byte_t timeoutCtrl_ff;
    dlicr_byte_t fwdCtrl_ff;
    dlicr_byte_t rdData_ff;

    function automatic logic hitReg(input dlicr_byte_t addr, input dlicr_byte_t ofs);
        hitReg = addr == ofs;
    endfunction : hitReg

    wire logic wrMisc = regWrEn && hitReg(regAddr, `DLICR_OFS_LINK_MISC);
    wire logic wrTimeout = regWrEn && hitReg(regAddr, `DLICR_OFS_TIMEOUT);
    wire logic wrFwd = regWrEn && hitReg(regAddr, `DLICR_OFS_FORWARD);
    wire dlicr_byte_t roMask = 8'h01 << `DLICR_BIT_RSVD_RO;
    wire dlicr_byte_t nxt_linkMisc = (regWrData & ~roMask) | (`DLICR_RST_LINK_MISC & roMask);
    wire dlicr_byte_t nxt_rdData = hitReg(regAddr, `DLICR_OFS_LINK_MISC) ? linkMisc_ff :
                                   hitReg(regAddr, `DLICR_OFS_TIMEOUT) ? timeoutCtrl_ff :
                                   hitReg(regAddr, `DLICR_OFS_FORWARD) ? fwdCtrl_ff : 8'h00;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            linkMisc_ff <= `DLICR_RST_LINK_MISC;
            timeoutCtrl_ff <= `DLICR_RST_TIMEOUT;
            fwdCtrl_ff <= `DLICR_RST_FORWARD;
            rdData_ff <= 8'h00;
        end
        else
        begin
            if (wrMisc)
                linkMisc_ff <= nxt_linkMisc;
            if (wrTimeout)
                timeoutCtrl_ff <= regWrData;
            if (wrFwd)
                fwdCtrl_ff <= regWrData;
            if (regRdEn)
                rdData_ff <= nxt_rdData;
        end
    end
    assign regRdData = rdData_ff;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    wire logic syncFiltEn = linkMisc_ff[`DLICR_BIT_SYNC_FILT];
    wire logic passMatch = linkMisc_ff[`DLICR_BIT_PASS_MATCH];
    wire logic autoAck = linkMisc_ff[`DLICR_BIT_AUTO_ACK];
    wire logic pixelGateByValid = linkMisc_ff[`DLICR_BIT_PIX_GATE];
    wire logic [6:0] ctrlChanTimeoutVal = timeoutCtrl_ff[`DLICR_TO_VAL_HI:`DLICR_TO_VAL_LO];
    wire logic ctrlChanTimeoutOff = timeoutCtrl_ff[`DLICR_BIT_TO_OFF];
    wire logic passAll = fwdCtrl_ff[`DLICR_BIT_PASS_ALL];
    wire logic [2:0] sdaHoldField = fwdCtrl_ff[`DLICR_HOLD_HI:`DLICR_HOLD_LO];
    wire logic [3:0] filtDepth = fwdCtrl_ff[`DLICR_FDEPTH_HI:`DLICR_FDEPTH_LO];

    // ------------------------------------------------------------------
    // Sync and serial-bus glitch filters
    // ------------------------------------------------------------------
    wire dlicr_byte_t hsMin = dualLane ? `DLICR_SYNC_MIN_DUAL : `DLICR_SYNC_MIN_SINGLE;
    wire dlicr_byte_t glitchNs = 8'({4'h0, filtDepth} * `DLICR_GLITCH_UNIT_NS);
    wire dlicr_byte_t glitchMin = 8'(glitchNs / `DLICR_CLK_PERIOD_NS + 1);
    wire logic [`DLICR_FILT_COUNT-1:0] fIn = {sdaIn, sclIn, vsIn, hsIn, deIn};
    wire logic [`DLICR_FILT_COUNT-1:0] fEn = {1'b1, 1'b1, syncFiltEn, syncFiltEn, syncFiltEn};
    wire dlicr_byte_t fMin [`DLICR_FILT_COUNT];
    logic [`DLICR_FILT_COUNT-1:0] fOut;

    assign fMin[0] = `DLICR_SYNC_MIN_SINGLE;
    assign fMin[1] = hsMin;
    assign fMin[2] = `DLICR_SYNC_MIN_SINGLE;
    assign fMin[3] = glitchMin;
    assign fMin[4] = glitchMin;

    genvar gi;
    generate
        for (gi = 0; gi < `DLICR_FILT_COUNT; gi++)
        begin : gFilt
            dlicr_pulse_filter uFilt (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .filtEn(fEn[gi]),
                .minLen(fMin[gi]),
                .sigIn(fIn[gi]),
                .sigOut(fOut[gi])
            );
        end
    endgenerate
    assign deOut = fOut[0];
    assign hsOut = fOut[1];
    assign vsOut = fOut[2];
    assign sclClean = fOut[3];

    // ------------------------------------------------------------------
    // SDA hold after SCL falls
    // ------------------------------------------------------------------
    localparam int HOLD_UNIT_CYCLES = `DLICR_HOLD_UNIT_NS / `DLICR_CLK_PERIOD_NS;
    logic sclPrev_ff;
    logic [5:0] holdCnt_ff;
    logic sdaHeld_ff;
    wire logic sclFell = sclPrev_ff && !fOut[3];
    wire logic [5:0] holdLoad = 6'({3'h0, sdaHoldField} * HOLD_UNIT_CYCLES);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sclPrev_ff <= 1'b0;
            holdCnt_ff <= 6'h00;
            sdaHeld_ff <= 1'b1;
        end
        else
        begin
            sclPrev_ff <= fOut[3];
            if (sclFell)
                holdCnt_ff <= holdLoad;
            else if (holdCnt_ff != 6'h00)
                holdCnt_ff <= holdCnt_ff - 6'h01;
            if (!sclFell && holdCnt_ff == 6'h00)
                sdaHeld_ff <= fOut[4];
        end
    end
    assign sdaHeld = sdaHeld_ff;

    // ------------------------------------------------------------------
    // Forwarding, acknowledge, pixel gating, back channel
    // ------------------------------------------------------------------
    logic fwd_ff;
    logic ack_ff;
    logic bcActive_ff;
    logic crcEn_ff;
    logic pullSel_ff;
    dlicr_pixel_t pix_ff;
    wire logic nxt_fwd = txnStart && (passAll || (passMatch && addrMatch));
    wire logic nxt_ack = wrAddressed && (autoAck || fwdLocked);
    wire logic gateActive = partnerProtected || pixelGateByValid;
    wire dlicr_pixel_t nxt_pix = (gateActive && !deIn) ? 24'h000000 : pixIn;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            fwd_ff <= 1'b0;
            ack_ff <= 1'b0;
            bcActive_ff <= 1'b1;
            crcEn_ff <= 1'b1;
            pullSel_ff <= 1'b1;
            pix_ff <= 24'h000000;
        end
        else
        begin
            fwd_ff <= nxt_fwd;
            ack_ff <= nxt_ack;
            bcActive_ff <= backChanOn || passMatch || passAll;
            crcEn_ff <= linkMisc_ff[`DLICR_BIT_CRC_GEN];
            pullSel_ff <= linkMisc_ff[`DLICR_BIT_PULL_SEL];
            pix_ff <= nxt_pix;
        end
    end
    assign fwdToRemote = fwd_ff;
    assign wrAck = ack_ff;
    assign backChanActive = bcActive_ff;
    assign backChanCrcGenEn = crcEn_ff;
    assign undrivenInputPullSel = pullSel_ff;
    assign pixOut = pix_ff;

    // ------------------------------------------------------------------
    // Control-channel watchdog
    // ------------------------------------------------------------------
    logic [17:0] stepCnt_ff;
    logic [6:0] elapsed_ff;
    logic abort_ff;
    wire logic wdRun = ccBusy && !ctrlChanTimeoutOff;
    wire logic stepTick = stepCnt_ff == 18'(TO_STEP_CYCLES - 1);
    wire logic [6:0] elapsedInc = elapsed_ff + 7'h01;
    wire logic expire = wdRun && stepTick && elapsedInc >= ctrlChanTimeoutVal;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            stepCnt_ff <= 18'h00000;
            elapsed_ff <= 7'h00;
            abort_ff <= 1'b0;
        end
        else
        begin
            abort_ff <= expire;
            if (!wdRun || expire)
            begin
                stepCnt_ff <= 18'h00000;
                elapsed_ff <= 7'h00;
            end
            else if (stepTick)
            begin
                stepCnt_ff <= 18'h00000;
                elapsed_ff <= elapsedInc;
            end
            else
                stepCnt_ff <= stepCnt_ff + 18'h00001;
        end
    end
    assign ccAbort = abort_ff;
endmodule : dlicr_config_regs

// [dlicr_consts.svh]
/*
 * Offsets, field positions, reset values and timing figures of the link
 * configuration register bank.
 * Assumes a 100 MHz system clock and 8-bit registers.
 */
`ifndef DLICR_CONSTS_SVH
`define DLICR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DLICR_OFS_LINK_MISC 8'h03
`define DLICR_OFS_TIMEOUT 8'h04
`define DLICR_OFS_FORWARD 8'h05

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DLICR_RST_LINK_MISC 8'hF0
`define DLICR_RST_TIMEOUT 8'hFE
`define DLICR_RST_FORWARD 8'h1E

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DLICR_BIT_RSVD_RW 7
`define DLICR_BIT_CRC_GEN 6
`define DLICR_BIT_PULL_SEL 5
`define DLICR_BIT_SYNC_FILT 4
`define DLICR_BIT_PASS_MATCH 3
`define DLICR_BIT_AUTO_ACK 2
`define DLICR_BIT_PIX_GATE 1
`define DLICR_BIT_RSVD_RO 0
`define DLICR_TO_VAL_HI 7
`define DLICR_TO_VAL_LO 1
`define DLICR_BIT_TO_OFF 0
`define DLICR_BIT_PASS_ALL 7
`define DLICR_HOLD_HI 6
`define DLICR_HOLD_LO 4
`define DLICR_FDEPTH_HI 3
`define DLICR_FDEPTH_LO 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DLICR_CLK_PERIOD_NS 10
`define DLICR_TO_STEP_MS 2
`define DLICR_HOLD_UNIT_NS 50
`define DLICR_GLITCH_UNIT_NS 5
`define DLICR_SYNC_MIN_SINGLE 8'h02
`define DLICR_SYNC_MIN_DUAL 8'h04
`define DLICR_FILT_COUNT 5

`endif

// [dlicr_pkg.sv]
/*
 * Types shared by the link configuration register bank.
 * Assumes dlicr_consts.svh is available on the include path.
 */
package dlicr_pkg;
    typedef logic [7:0] dlicr_byte_t;
    typedef logic [23:0] dlicr_pixel_t;
endpackage : dlicr_pkg

// [dlicr_pulse_filter.sv]
/*
 * Pulse-width filter: the output follows the input only after the input
 * has held a new level for minLen cycles.
 * Assumes the input is synchronous to mclk and minLen is at least one.
 */
`timescale 1ns/1ps
module dlicr_pulse_filter
    import dlicr_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic filtEn,
    input wire dlicr_byte_t minLen,
    input wire logic sigIn,
    output logic sigOut
);
    dlicr_byte_t cnt_ff;
    logic out_ff;
    wire dlicr_byte_t cntInc = cnt_ff + 8'h01;
    wire logic changed = sigIn != out_ff;
    wire logic longEnough = cntInc >= minLen;

    assign sigOut = out_ff;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            // Start at the input level so idle-high lines show no false edge after reset
            out_ff <= sigIn;
            cnt_ff <= 8'h00;
        end
        else if (!filtEn || (changed && longEnough))
        begin
            out_ff <= sigIn;
            cnt_ff <= 8'h00;
        end
        else
        begin
            cnt_ff <= changed ? cntInc : 8'h00;
        end
    end
endmodule : dlicr_pulse_filter

// [dlicr_config_asserts.sv]
/*
 * Port checker for the link configuration register bank.
 * Assumes it is bound to dlicr_config_regs and sees only its ports.
 */
`timescale 1ns/1ps
module dlicr_config_asserts
    import dlicr_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic regRdEn,
    input wire dlicr_byte_t regAddr,
    input wire dlicr_byte_t regRdData,
    input wire logic backChanOn,
    input wire logic partnerProtected,
    input wire logic deIn,
    input wire logic hsIn,
    input wire dlicr_pixel_t pixOut,
    input wire logic deOut,
    input wire logic hsOut,
    input wire logic txnStart,
    input wire logic fwdToRemote,
    input wire logic wrAddressed,
    input wire logic wrAck,
    input wire logic ccBusy,
    input wire logic ccAbort,
    input wire logic backChanActive
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_fwd_cause: assert property (!txnStart |=> !fwdToRemote) else $error("forward without start");
    a_ack_cause: assert property (!wrAddressed |=> !wrAck) else $error("ack without write");
    a_abort_busy: assert property (ccAbort |-> $past(ccBusy)) else $error("abort while idle");
    a_abort_once: assert property (ccAbort |=> !ccAbort) else $error("abort longer than one cycle");
    a_pix_gate: assert property (partnerProtected && !deIn |=> pixOut == 24'h000000) else $error("pixel not gated");
    a_bc_held: assert property (backChanOn |=> backChanActive) else $error("back channel dropped");
    a_rd_unmap: assert property (regRdEn && (regAddr < 8'h03 || regAddr > 8'h05) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_de_filt: assert property ($changed(deOut) |-> deOut == $past(deIn)) else $error("enable out of step");
    a_hs_filt: assert property ($changed(hsOut) |-> hsOut == $past(hsIn)) else $error("hsync out of step");
endmodule : dlicr_config_asserts

bind dlicr_config_regs dlicr_config_asserts u_chk (.mclk, .sys_rst, .regRdEn, .regAddr, .regRdData, .backChanOn,
    .partnerProtected, .deIn, .hsIn, .pixOut, .deOut, .hsOut, .txnStart, .fwdToRemote, .wrAddressed, .wrAck,
    .ccBusy, .ccAbort, .backChanActive);

// [dlicr_cc_peer.sv]
/*
 * Serial-bus target engine and control channel seen from the bank.
 * Assumes the caller enters each task just after a rising edge.
 */
`timescale 1ns/1ps
module dlicr_cc_peer
(
    input wire logic mclk,
    input wire logic ccAbort,
    output logic txnStart,
    output logic addrMatch,
    output logic wrAddressed,
    output logic fwdLocked,
    output logic ccBusy
);
    initial
    begin
        txnStart = 0; addrMatch = 0; wrAddressed = 0; fwdLocked = 0; ccBusy = 0;
    end
    // Decoded address phase of a write, then idle with address match inverted and lock kept
    task automatic offer(input logic m, input logic lk);
        txnStart = 1; addrMatch = m; wrAddressed = 1; fwdLocked = lk;
        @(posedge mclk) #1;
        txnStart = 0; addrMatch = !m; wrAddressed = 0;
    endtask : offer
    // Holds a transaction open until aborted or lim cycles pass
    task automatic busy(input int lim, output int n);
        ccBusy = 1;
        n = 0;
        while (n < lim && ccAbort !== 1'b1)
        begin
            @(posedge mclk) #1;
            n++;
        end
        ccBusy = 0;
        @(posedge mclk) #1;
    endtask : busy
endmodule : dlicr_cc_peer

// [deser_link_i2c_config_regs_test.sv]
/*
 * Self-checking bench for the link configuration register bank.
 * Assumes a short watchdog step parameter and a 100 MHz clock.
 */
`timescale 1ns/1ps
module deser_link_i2c_config_regs_test
    import dlicr_pkg::*;
;
    localparam int STEP = 4;
    logic mclk, sys_rst, regWrEn, regRdEn, backChanOn, dualLane, partnerProtected, deIn, hsIn, vsIn, sclIn, sdaIn;
    dlicr_byte_t regAddr, regWrData, regRdData;
    dlicr_pixel_t pixIn, pixOut;
    logic deOut, hsOut, txnStart, addrMatch, fwdToRemote, wrAddressed, fwdLocked, wrAck, ccBusy, ccAbort;
    logic vsOut, sclClean, sdaHeld;
    logic backChanActive, backChanCrcGenEn, undrivenInputPullSel, sh, sd, sv;
    int err_count = 0, checks_done = 0, i, j, k, n, mreg[3];
    logic [31:0] v;

    dlicr_config_regs #(.TO_STEP_CYCLES(STEP)) u_dut (.mclk, .sys_rst, .regWrEn, .regRdEn, .regAddr, .regWrData,
        .regRdData, .backChanOn, .dualLane, .partnerProtected, .deIn, .hsIn, .vsIn, .pixIn, .deOut, .hsOut,
        .vsOut, .pixOut, .sclIn, .sdaIn, .sclClean, .sdaHeld, .txnStart, .addrMatch, .fwdToRemote,
        .wrAddressed, .fwdLocked, .wrAck, .ccBusy, .ccAbort, .backChanActive, .backChanCrcGenEn, .undrivenInputPullSel);
    dlicr_cc_peer u_peer (.mclk, .ccAbort, .txnStart, .addrMatch, .wrAddressed, .fwdLocked, .ccBusy);

    task automatic tick();
        @(posedge mclk) #1;
    endtask : tick
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wr(input dlicr_byte_t a, input dlicr_byte_t d);
        regAddr = a; regWrData = d; regWrEn = 1;
        tick();
        regWrEn = 0;
        tick();
        if (a >= 8'h03 && a <= 8'h05)
            mreg[a - 8'h03] = (a == 8'h03) ? d & 8'hFE : d;
    endtask : wr
    task automatic rd_chk(input dlicr_byte_t a);
        regAddr = a; regRdEn = 1;
        tick();
        regRdEn = 0;
        chk(regRdData, (a >= 8'h03 && a <= 8'h05) ? 24'(mreg[a - 8'h03]) : 24'h0, "read");
        tick();
    endtask : rd_chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        repeat (3000) @(posedge mclk);
        err_count++;
        $display("[ERR] %0t run hung", $time);
        wrap_up();
    end
    // ----------------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------------
    initial
    begin
        sys_rst = 1; regWrEn = 0; regRdEn = 0; regAddr = 0; regWrData = 0; backChanOn = 0; dualLane = 0;
        partnerProtected = 0; deIn = 0; hsIn = 0; vsIn = 0; pixIn = 0; sclIn = 1; sdaIn = 1;
        v = $urandom(32'h26181992);
        mreg = '{8'hF0, 8'hFE, 8'h1E};
        repeat (2) @(posedge mclk);
        #1 sys_rst = 0;
        chk(backChanCrcGenEn, 1, "crc reset");
        chk(undrivenInputPullSel, 1, "pull reset");
        for (i = 2; i < 8; i++) rd_chk(8'(i));
        $display("reset values done");
        repeat (4)
        begin
            v = $urandom;
            wr(8'h03, v[7:0]);
            rd_chk(8'h03);
            chk(backChanCrcGenEn, v[6], "crc");
            chk(undrivenInputPullSel, v[5], "pull");
            wr(8'h05, v[15:8]);
            rd_chk(8'h05);
        end
        $display("register access done");
        for (i = 0; i < 32; i++)
        begin
            wr(8'h03, {4'hF, i[0], i[3], 2'b00});
            wr(8'h05, {i[1], 7'h1E});
            backChanOn = i[4];
            u_peer.offer(i[2], i[4]);
            chk(fwdToRemote, (i[0] & i[2]) | i[1], "forward");
            chk(wrAck, i[3] | i[4], "ack");
            chk(backChanActive, i[0] | i[1] | i[4], "back channel");
        end
        $display("forwarding done");
        for (i = 0; i < 8; i++)
        begin
            wr(8'h03, {6'h3C, i[1], 1'b0});
            partnerProtected = i[0]; deIn = i[2]; v = $urandom; pixIn = v[23:0];
            tick();
            chk(pixOut, ((i[0] | i[1]) && !i[2]) ? 24'h0 : v[23:0], "pixel");
        end
        $display("pixel gating done");
        for (i = 0; i < 2; i++)
        begin
            dualLane = i[0]; hsIn = 0; deIn = 0; sh = 0; sd = 0;
            vsIn = 0;
            sv = 0;
            repeat (6) tick();
            for (j = 0; j < 12; j++)
            begin
                hsIn = j < 3; deIn = j < 1;
                vsIn = j < 2;
                tick();
                sh |= hsOut; sd |= deOut;
                sv |= vsOut;
            end
            chk(sd, 0, "enable glitch");
            chk(sh, !i[0], "hsync pulse");
            chk(sv, 1, "vsync pulse");
        end
        $display("sync filter done");
        v = $urandom;
        wr(8'h05, {1'b0, v[6:4], 4'hE});
        sclIn = 0;
        repeat (7) tick();
        sclIn = 1;
        sh = 1;
        repeat (12)
        begin
            tick();
            sh &= sclClean;
        end
        chk(sh, 1, "scl glitch");
        sclIn = 0;
        sdaIn = 0;
        j = 0;
        n = 0;
        for (k = 1; k < 50; k++)
        begin
            tick();
            if (j == 0 && sclClean === 1'b0)
                j = k;
            if (n == 0 && sdaHeld === 1'b0)
                n = k;
        end
        chk(j, 4'hE * 5 / 10 + 1, "scl filter");
        chk(n - j >= v[6:4] * 5 && n - j <= v[6:4] * 5 + 2, 1, "sda hold");
        sclIn = 1;
        sdaIn = 1;
        repeat (10) tick();
        $display("serial bus filter done");
        wr(8'h04, 8'h04);
        rd_chk(8'h04);
        u_peer.busy(40, n);
        chk(n >= 2 * STEP && n <= 2 * STEP + 2, 1, "abort time");
        wr(8'h04, 8'h05);
        u_peer.busy(40, n);
        chk(n, 40, "timer off");
        $display("watchdog done");
        wrap_up();
    end
endmodule : deser_link_i2c_config_regs_test
